// *** rtl/apsc_pkg.sv ***
// constants and types for the antenna port switch controller
package apsc_pkg;
    // secondary port code: bit 2 is bank (0 = bank a, 1 = bank b), bits 1:0 port index
    localparam logic [2:0] PORT_A1_CODE   = 3'h0;
    localparam logic [2:0] PORT_B1_CODE   = 3'h4;
    localparam int         BANK_BIT       = 2;
    localparam int         NUM_BANDS      = 8;
    localparam int         NUM_STEPS      = 8;
    localparam int         FREQ_W         = 16;   // MHz
    localparam int         DWELL_W        = 16;   // sample periods
    localparam logic [15:0] DWELL_DEFAULT = 16'h03e8; // 1000 samples
    localparam logic [2:0] BCAST_ADDR     = 3'h0;
    // register map, word offsets on the local port
    localparam logic [7:0] REG_MODE       = 8'h00; // [1:0] mode
    localparam logic [7:0] REG_MANUAL     = 8'h01; // [2:0] left, [3] left_valid, [6:4] right, [7] right_valid
    localparam logic [7:0] REG_STATUS     = 8'h02; // [2:0] left, [5:3] right, [8:6] board address
    localparam logic [7:0] REG_BAND_CNT   = 8'h03; // [3:0] number of bands in use
    localparam logic [7:0] REG_STEP_CNT   = 8'h04; // [3:0] number of time steps in use
    localparam logic [7:0] REG_DWELL_DEF  = 8'h05; // [15:0] default dwell
    localparam logic [7:0] REG_TUNE       = 8'h06; // [15:0] tuned MHz, write = retune
    localparam logic [7:0] REG_BAND_BASE  = 8'h10; // +i: [2:0] port, [31:16] max, [15:3] unused
    localparam logic [7:0] REG_BMIN_BASE  = 8'h18; // +i: [15:0] min
    localparam logic [7:0] REG_STEP_BASE  = 8'h20; // +i: [2:0] port, [3] own dwell, [31:16] dwell
    localparam logic [7:0] REG_UNMAPPED   = 8'hff;
    // field positions inside the write data
    localparam int         MAN_LEFT_LSB   = 0;
    localparam int         MAN_LEFT_VLD   = 3;
    localparam int         MAN_RIGHT_LSB  = 4;
    localparam int         MAN_RIGHT_VLD  = 7;
    localparam int         STEP_OWN_BIT   = 3;
    localparam int         UPPER_LSB      = 16;
    typedef enum logic [1:0] {
        APSC_MANUAL = 2'b00,
        APSC_FREQ   = 2'b01,
        APSC_TIME   = 2'b10
    } apsc_mode_t;
endpackage : apsc_pkg

// *** rtl/apsc_ctrl.sv ***
// antenna port switch controller: routing, modes, leds and board address
// Summary of operation
// - each primary always routed; reset to first secondaries
// - never both primaries in one bank
// - green leds for left, yellow for right
// - board address from three weighted jumpers
// - act only on commands for own address; plan registers also on broadcast
// - unset primary goes to opposite first secondary
// - manual, frequency, time modes; manual after reset
// - frequency mode replans left on every retune while band count is not zero
// - first matching band wins, last is fallback
// - right mirrors left into opposite bank
// - automatic mode persists until host changes it
// - time mode steps list by dwell samples
// - default dwell for entries without own
// - stacked boards share one switching plan
`timescale 1ns/1ps
`default_nettype none
module apsc_ctrl
    import apsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  address_jumper_header,  // 1 = jumper fitted
    input  wire logic [2:0]  cmd_board,              // board the access targets
    input  wire logic        cmd_all,                // plan write to every board
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        sample_tick,            // one pulse per host sample period
    output logic      [31:0] reg_rdata,
    output logic      [2:0]  primary_port_left,
    output logic      [2:0]  primary_port_right,
    output logic      [7:0]  led_green,              // secondary leds of left primary
    output logic      [7:0]  led_yellow,             // secondary leds of right primary
    output logic             led_left_primary,
    output logic             led_right_primary
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // identity and operating mode
    logic [2:0]          board_addr;
    apsc_mode_t          mode;
    // plan sizes and shared settings
    logic [3:0]          band_cnt;
    logic [3:0]          step_cnt;
    logic [DWELL_W-1:0]  dwell_def;
    logic [FREQ_W-1:0]   tune_mhz;
    // band table, one entry per listed band
    logic [2:0]          band_port [NUM_BANDS];
    logic [FREQ_W-1:0]   band_min  [NUM_BANDS];
    logic [FREQ_W-1:0]   band_max  [NUM_BANDS];
    // step table, one entry per listed step
    logic [2:0]          step_port [NUM_STEPS];
    logic                step_own  [NUM_STEPS];
    logic [DWELL_W-1:0]  step_dwell[NUM_STEPS];
    // sequencer position and retune pulse
    logic [2:0]          step_idx;
    logic [DWELL_W-1:0]  dwell_cnt;
    logic                retune;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // manual routing is per board; plan registers also take broadcast
    // so stacked boards can be loaded with one shared plan
    wire        is_mine   = (cmd_board == board_addr);
    wire        wr_mine   = reg_wr && is_mine;
    wire        wr_plan   = reg_wr && (is_mine || cmd_all);
    wire        sel_mode  = (reg_addr == REG_MODE);
    wire        sel_man   = (reg_addr == REG_MANUAL);
    wire        sel_bcnt  = (reg_addr == REG_BAND_CNT);
    wire        sel_scnt  = (reg_addr == REG_STEP_CNT);
    wire        sel_ddef  = (reg_addr == REG_DWELL_DEF);
    wire        sel_tune  = (reg_addr == REG_TUNE);
    // table windows decode on the upper five address bits
    wire        sel_band  = (reg_addr[7:3] == REG_BAND_BASE[7:3]);
    wire        sel_bmin  = (reg_addr[7:3] == REG_BMIN_BASE[7:3]);
    wire        sel_step  = (reg_addr[7:3] == REG_STEP_BASE[7:3]);
    wire [2:0]  idx       = reg_addr[2:0];
    wire [1:0]  wmode     = reg_wdata[1:0];
    // mode code 3 is not a mode and is dropped
    wire        mode_ok   = (wmode != 2'b11);

    // ------------------------------------------------------------
    // manual configuration resolution
    // ------------------------------------------------------------
    wire [2:0]  man_l     = reg_wdata[MAN_LEFT_LSB +: 3];
    wire        man_lv    = reg_wdata[MAN_LEFT_VLD];
    wire [2:0]  man_r     = reg_wdata[MAN_RIGHT_LSB +: 3];
    wire        man_rv    = reg_wdata[MAN_RIGHT_VLD];
    // a missing half goes to the first port of the other bank,
    // so it can never collide with the half that was given
    wire [2:0]  opp_l     = man_l[BANK_BIT] ? PORT_A1_CODE : PORT_B1_CODE;
    wire [2:0]  opp_r     = man_r[BANK_BIT] ? PORT_A1_CODE : PORT_B1_CODE;
    wire [2:0]  res_l     = man_lv ? man_l : opp_r;
    wire [2:0]  res_r     = man_rv ? man_r : opp_l;
    // same-bank or empty requests are refused
    wire        man_ok    = (man_lv || man_rv) &&
                            (res_l[BANK_BIT] != res_r[BANK_BIT]);
    // only honoured in manual mode, so an automatic plan is never
    // overridden while it runs
    wire        man_take  = wr_mine && sel_man && man_ok && (mode == APSC_MANUAL);

    // ------------------------------------------------------------
    // frequency band search, first match wins
    // ------------------------------------------------------------
    // scan from the top so the lowest matching index is assigned last
    // and wins; with no match the last band in use is the fallback
    logic [2:0] band_hit;
    always_comb begin
        band_hit = band_port[3'(band_cnt - 4'h1)];
        for (int i = NUM_BANDS - 1; i >= 0; i--) begin
            if ((4'(i) < band_cnt) && (tune_mhz >= band_min[i])
                && (tune_mhz <= band_max[i])) begin
                band_hit = band_port[i];
            end
        end
    end

    // ------------------------------------------------------------
    // time stepping
    // ------------------------------------------------------------
    // entries without their own dwell use the shared default
    wire [DWELL_W-1:0] cur_dwell = step_own[step_idx] ? step_dwell[step_idx] : dwell_def;
    // the parked index 7 counts as last, so the first step lands on 0
    wire        last_step = ({1'b0, step_idx} >= 4'(step_cnt - 4'h1));
    wire [2:0]  nstep     = last_step ? 3'h0 : 3'(step_idx + 3'h1);
    // dwell ends on the tick that completes the count
    wire        dwell_end = sample_tick && (dwell_cnt + 16'h1 >= cur_dwell);
    wire        time_go   = (mode == APSC_TIME) && (step_cnt != 4'h0) && dwell_end;
    wire        freq_go   = (mode == APSC_FREQ) && retune && (band_cnt != 4'h0);

    // ------------------------------------------------------------
    // next routing of both primaries
    // ------------------------------------------------------------
    // right is always derived from left in the automatic modes,
    // so the two can never share a bank
    wire [2:0]  auto_l    = time_go ? step_port[nstep] : band_hit;
    wire [2:0]  auto_r    = {~auto_l[BANK_BIT], auto_l[1:0]};
    wire        auto_go   = time_go || freq_go;
    // manual and automatic updates need different modes and never meet
    wire [2:0]  next_left  = man_take ? res_l : (auto_go ? auto_l : primary_port_left);
    wire [2:0]  next_right = man_take ? res_r : (auto_go ? auto_r : primary_port_right);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // foreign boards read zero so stacked boards can share the port
    wire [31:0] rd_mux =
        !is_mine ? 32'h0 :
        sel_mode ? {30'h0, mode} :
        sel_bcnt ? {28'h0, band_cnt} :
        sel_scnt ? {28'h0, step_cnt} :
        sel_ddef ? {16'h0, dwell_def} :
        sel_tune ? {16'h0, tune_mhz} :
        (reg_addr == REG_STATUS) ? {23'h0, board_addr, primary_port_right, primary_port_left} :
        sel_band ? {band_max[idx], 13'h0, band_port[idx]} :
        sel_bmin ? {16'h0, band_min[idx]} :
        sel_step ? {step_dwell[idx], 12'h0, step_own[idx], step_port[idx]} :
        32'h0;

    // ------------------------------------------------------------
    // board address capture after reset release
    // ------------------------------------------------------------
    // jumpers are sampled every cycle; a change acts on the next edge,
    // and the reset value is the address with no jumpers fitted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            board_addr <= 3'h0;
        end else begin
            board_addr <= address_jumper_header;
        end
    end

    // ------------------------------------------------------------
    // routing outputs, updated together
    // ------------------------------------------------------------
    // both primaries load on the same edge, so no cycle ever shows
    // a half-applied change with both in one bank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_port_left  <= PORT_A1_CODE;
            primary_port_right <= PORT_B1_CODE;
        end else begin
            primary_port_left  <= next_left;
            primary_port_right <= next_right;
        end
    end

    // ------------------------------------------------------------
    // leds follow the registered routing
    // ------------------------------------------------------------
    // loaded from the next routing so they change on the same edge
    // as the ports and never lag them by a cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_green         <= 8'h00;
            led_yellow        <= 8'h00;
            led_left_primary  <= 1'b0;
            led_right_primary <= 1'b0;
        end else begin
            led_green         <= 8'h01 << next_left;
            led_yellow        <= 8'h01 << next_right;
            led_left_primary  <= 1'b1;
            led_right_primary <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // mode and global settings
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode      <= APSC_MANUAL;
            band_cnt  <= 4'h0;
            step_cnt  <= 4'h0;
            dwell_def <= DWELL_DEFAULT;
            tune_mhz  <= 16'h0;
            retune    <= 1'b0;
        end else begin
            // one-cycle pulse after each tune write
            retune <= wr_plan && sel_tune;
            if (wr_plan && sel_mode && mode_ok) begin
                mode <= apsc_mode_t'(wmode);
            end
            // counts above the table depth are clamped to the depth
            if (wr_plan && sel_bcnt) begin
                band_cnt <= (reg_wdata[3:0] > 4'h8) ? 4'h8 : reg_wdata[3:0];
            end
            if (wr_plan && sel_scnt) begin
                step_cnt <= (reg_wdata[3:0] > 4'h8) ? 4'h8 : reg_wdata[3:0];
            end
            if (wr_plan && sel_ddef) begin
                dwell_def <= reg_wdata[15:0];
            end
            if (wr_plan && sel_tune) begin
                tune_mhz <= reg_wdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // band and step tables
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_BANDS; i++) begin
                band_port[i]  <= PORT_A1_CODE;
                band_min[i]   <= 16'h0;
                band_max[i]   <= 16'h0;
                step_port[i]  <= PORT_A1_CODE;
                step_own[i]   <= 1'b0;
                step_dwell[i] <= 16'h0;
            end
        end else begin
            if (wr_plan && sel_band) begin
                band_port[idx] <= reg_wdata[2:0];
                band_max[idx]  <= reg_wdata[UPPER_LSB +: FREQ_W];
            end
            if (wr_plan && sel_bmin) begin
                band_min[idx] <= reg_wdata[15:0];
            end
            if (wr_plan && sel_step) begin
                step_port[idx]  <= reg_wdata[2:0];
                step_own[idx]   <= reg_wdata[STEP_OWN_BIT];
                step_dwell[idx] <= reg_wdata[UPPER_LSB +: DWELL_W];
            end
        end
    end

    // ------------------------------------------------------------
    // time mode sequencer
    // ------------------------------------------------------------
    // leaving time mode parks the index so a later entry starts afresh
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_idx  <= 3'h0;
            dwell_cnt <= 16'h0;
        end else if (mode != APSC_TIME) begin
            step_idx  <= 3'h7;             // first step lands on entry 0
            dwell_cnt <= 16'h0;
        end else if (time_go) begin
            step_idx  <= nstep;
            dwell_cnt <= 16'h0;
        end else if (sample_tick) begin
            dwell_cnt <= 16'(dwell_cnt + 16'h1);
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    // zero outside the answer cycle keeps the port quiet between reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end
endmodule : apsc_ctrl
`default_nettype wire

// *** tb/apsc_ctrl_checker.sv ***
// port assertions for the antenna port switch controller
`timescale 1ns/1ps
`default_nettype none
module apsc_ctrl_checker
    import apsc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [2:0]  address_jumper_header,
    input wire logic [2:0]  cmd_board,
    input wire logic        cmd_all,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        sample_tick,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  primary_port_left,
    input wire logic [2:0]  primary_port_right,
    input wire logic [7:0]  led_green,
    input wire logic [7:0]  led_yellow,
    input wire logic        led_left_primary,
    input wire logic        led_right_primary
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    rst_route_a: assert property ($rose(rst_n) |-> primary_port_left == PORT_A1_CODE
        && primary_port_right == PORT_B1_CODE) else $error("reset routing wrong");
    bank_apart_a: assert property (primary_port_left[BANK_BIT] != primary_port_right[BANK_BIT])
        else $error("both primaries in one bank");
    green_led_a: assert property ($past(rst_n) |-> led_green == (8'h01 << primary_port_left))
        else $error("green leds differ from left routing");
    yellow_led_a: assert property ($past(rst_n) |-> led_yellow == (8'h01 << primary_port_right))
        else $error("yellow leds differ from right routing");
    primary_led_a: assert property ($past(rst_n) |-> led_left_primary && led_right_primary)
        else $error("primary led dark");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer");
    status_read_a: assert property (reg_rd && reg_addr == REG_STATUS && $past(rst_n)
        && cmd_board == address_jumper_header |=> reg_rdata[8:0] == {$past(address_jumper_header),
        $past(primary_port_right), $past(primary_port_left)}) else $error("status read wrong");
    foreign_read_a: assert property (reg_rd && cmd_board != address_jumper_header
        |=> reg_rdata == 32'h0) else $error("foreign read answered");
    foreign_write_a: assert property (reg_wr && reg_addr == REG_MANUAL && !sample_tick
        && cmd_board != address_jumper_header |=> $stable(primary_port_left)
        && $stable(primary_port_right)) else $error("foreign manual write obeyed");
endmodule : apsc_ctrl_checker
bind apsc_ctrl apsc_ctrl_checker i_chk (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .address_jumper_header (address_jumper_header),
    .cmd_board             (cmd_board),
    .cmd_all               (cmd_all),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .sample_tick           (sample_tick),
    .reg_rdata             (reg_rdata),
    .primary_port_left     (primary_port_left),
    .primary_port_right    (primary_port_right),
    .led_green             (led_green),
    .led_yellow            (led_yellow),
    .led_left_primary      (led_left_primary),
    .led_right_primary     (led_right_primary)
);
`default_nettype wire

// *** tb/apsc_host.sv ***
// host controller model: register accesses and sample pulses
`timescale 1ns/1ps
`default_nettype none
module apsc_host (
    input  wire logic        clk,
    input  wire logic [31:0] reg_rdata,
    output logic      [2:0]  cmd_board,
    output logic             cmd_all,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             sample_tick
);
    initial begin
        cmd_board = 3'h0;
        cmd_all = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sample_tick = 1'b0;
    end
    // one write; board zero when the caller names none
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] b = 3'h0,
                      input logic all = 1'b0);
        @(posedge clk);
        cmd_board <= b;
        cmd_all <= all;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // released data must not keep its value
    endtask : wr
    // one read; data taken in the answer cycle
    task automatic rd(input logic [7:0] a, input logic [2:0] b, output logic [31:0] d);
        @(posedge clk);
        cmd_board <= b;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    // one sample period pulse
    task automatic tick();
        @(posedge clk);
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : tick
endmodule : apsc_host
`default_nettype wire

// *** tb/antenna_port_switch_controller_bench.sv ***
// self-checking bench for the antenna port switch controller
`timescale 1ns/1ps
`default_nettype none
module antenna_port_switch_controller_bench
    import apsc_pkg::*;
;
    localparam logic [2:0] ME = 3'h5; // jumpers fitted on weights 4 and 1
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  cmd_board, left, right;
    logic [2:0]  jumpers = ME;
    logic        cmd_all, reg_wr, reg_rd, sample_tick, led_l, led_r;
    logic [7:0]  reg_addr, led_green, led_yellow;
    logic [31:0] reg_wdata, reg_rdata, d;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n;
    always #20 clk = ~clk;
    apsc_host i_host (.clk(clk), .reg_rdata(reg_rdata), .cmd_board(cmd_board), .cmd_all(cmd_all),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .sample_tick(sample_tick));
    apsc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .address_jumper_header(jumpers),
        .cmd_board(cmd_board),
        .cmd_all(cmd_all), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .sample_tick(sample_tick), .reg_rdata(reg_rdata),
        .primary_port_left(left), .primary_port_right(right), .led_green(led_green),
        .led_yellow(led_yellow), .led_left_primary(led_l), .led_right_primary(led_r));
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic route(input logic [2:0] l, input logic [2:0] r);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("left", {29'h0, l}, {29'h0, left});
        chk("right", {29'h0, r}, {29'h0, right});
    endtask : route
    // manual routing, bank exclusion and board selection
    task automatic t_manual();
        route(3'h0, 3'h4);
        chk("leds", 32'h0110, {16'h0, led_green, led_yellow});
        chk("primary leds", 32'h3, {30'h0, led_l, led_r});
        i_host.wr(REG_MANUAL, 32'h0000000a, ME);
        route(3'h2, 3'h4);
        i_host.wr(REG_MANUAL, 32'h0000000e, ME);
        route(3'h6, 3'h0);
        i_host.wr(REG_MANUAL, 32'h000000a9, ME);
        route(3'h6, 3'h0);
        i_host.wr(REG_MANUAL, 32'h0000000a);
        route(3'h6, 3'h0);
        i_host.rd(REG_STATUS, ME, d);
        chk("status", 32'h00000146, d);
        i_host.rd(REG_UNMAPPED, ME, d);
        chk("unmapped", 32'h0, d);
    endtask : t_manual
    // mode selection and report
    task automatic t_mode();
        i_host.rd(REG_MODE, ME, d);
        chk("mode", 32'h0, d);
        i_host.wr(REG_MODE, 32'h3, ME);
        i_host.rd(REG_MODE, ME, d);
        chk("mode", 32'h0, d);
    endtask : t_mode
    // band table with first match and fallback
    task automatic t_freq();
        logic [15:0] f[3] = '{16'h0258, 16'h02bc, 16'h1388};
        logic [2:0]  p[3] = '{3'h0, 3'h2, 3'h6};
        i_host.wr(REG_BAND_BASE, 32'h02580000, ME);
        i_host.wr(REG_BMIN_BASE, 32'h00000064, ME);
        i_host.wr(REG_BAND_BASE + 8'h01, 32'h04b00002, ME);
        i_host.wr(REG_BMIN_BASE + 8'h01, 32'h00000258, ME);
        i_host.wr(REG_BAND_BASE + 8'h02, 32'h0fa00006, ME);
        i_host.wr(REG_BMIN_BASE + 8'h02, 32'h0, ME);
        i_host.wr(REG_BAND_CNT, 32'h3, ME);
        i_host.rd(REG_BAND_CNT, ME, d);
        chk("band count", 32'h3, d);
        i_host.rd(REG_BAND_BASE + 8'h01, ME, d);
        chk("band", 32'h04b00002, d);
        i_host.rd(REG_BMIN_BASE + 8'h01, ME, d);
        chk("band min", 32'h00000258, d);
        i_host.wr(REG_MODE, 32'h1, ME);
        i_host.rd(REG_MODE, ME, d);
        chk("mode", 32'h1, d);
        for (int i = 0; i < 3; i++) begin
            i_host.wr(REG_TUNE, {16'h0, f[i]}, ME);
            route(p[i], p[i] ^ 3'h4);
        end
        i_host.wr(REG_MANUAL, 32'h0000000a, ME);
        route(3'h6, 3'h2);
        i_host.rd(REG_TUNE, ME, d);
        chk("tune", 32'h00001388, d);
    endtask : t_freq
    // ticks until the left port reaches a code
    task automatic ticks_to(input logic [2:0] want);
        n = 0;
        while (left !== want && n < 12) begin
            i_host.tick();
            n++;
        end
        chk("right", {29'h0, want ^ 3'h4}, {29'h0, right});
    endtask : ticks_to
    // time stepping with own and default dwell, then wrap
    task automatic t_time();
        i_host.wr(REG_STEP_BASE, 32'h00020008, ME);
        i_host.wr(REG_STEP_BASE + 8'h01, 32'h00000001, ME);
        i_host.wr(REG_DWELL_DEF, 32'h3, ME);
        i_host.wr(REG_STEP_CNT, 32'h2, ME);
        i_host.rd(REG_STEP_BASE, ME, d);
        chk("step", 32'h00020008, d);
        i_host.rd(REG_DWELL_DEF, ME, d);
        chk("dwell default", 32'h3, d);
        i_host.rd(REG_STEP_CNT, ME, d);
        chk("step count", 32'h2, d);
        i_host.wr(REG_MODE, 32'h2, ME);
        ticks_to(3'h0);
        ticks_to(3'h1);
        chk("own dwell", 32'd2, n);
        ticks_to(3'h0);
        chk("default dwell", 32'd3, n);
        i_host.wr(REG_MODE, 32'h0, 3'h0, 1'b1);
        i_host.rd(REG_MODE, ME, d);
        chk("mode", 32'h0, d);
        i_host.wr(REG_BAND_CNT, 32'hf, ME);
        i_host.rd(REG_BAND_CNT, ME, d);
        chk("band clamp", NUM_BANDS, d);
    endtask : t_time
    // mid-run reset leaves time mode; no jumpers gives address zero
    task automatic t_reset();
        i_host.wr(REG_MODE, 32'h2, ME);
        @(posedge clk);
        rst_n   <= 1'b0;
        jumpers <= 3'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        i_host.rd(REG_MODE, 3'h0, d);
        chk("mode", 32'h0, d);
        i_host.rd(REG_STATUS, 3'h0, d);
        chk("status", 32'h00000020, d);
    endtask : t_reset
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_manual();
        t_mode();
        t_freq();
        t_time();
        t_reset();
        end_of_test();
    end
endmodule : antenna_port_switch_controller_bench
`default_nettype wire
